// >>> rtl/dcss_defines.svh
// Constants for the drive control signal selector.
// Assumes inclusion by its bare name from rtl/.
`ifndef DCSS_DEFINES_SVH
`define DCSS_DEFINES_SVH
// Source selection codes
`define DCSS_SRC_ON 10'h006
`define DCSS_SRC_OFF 10'h007
`define DCSS_SRC_IN1 10'h047
`define DCSS_SRC_IN2 10'h048
`define DCSS_SRC_IN3 10'h049
`define DCSS_SRC_IN4 10'h04A
`define DCSS_SRC_IN5 10'h04B
`define DCSS_SRC_HW_IN1 10'h20E
`define DCSS_SRC_HW_IN5 10'h212
`define DCSS_SRC_HW_MF1 10'h213
`define DCSS_SRC_HW_MF2 10'h214
`define DCSS_SRC_INV_LO 10'h219
`define DCSS_SRC_INV_HI 10'h220
// Reset values of the selections
`define DCSS_RST_SEL_FF1 10'h04A
`define DCSS_RST_SEL_DS1 10'h049
`define DCSS_RST_SEL_ACK 10'h04B
`define DCSS_RST_SEL_THERM 10'h214
`define DCSS_RST_MF_MODE 3'h3
// Multifunction digital modes
`define DCSS_MF_SINKING 3'h3
`define DCSS_MF_SOURCING 3'h4
// Control-location modes
`define DCSS_LOC_CONTACT 3'h0
`define DCSS_LOC_KEYPAD 3'h1
`define DCSS_LOC_KEYPAD_B 3'h3
`define DCSS_LOC_CONTACT_K 3'h4
`define DCSS_LOC_3WIRE 3'h5
// Control configurations with changeover
`define DCSS_CFG_FOC_A 10'h19A
`define DCSS_CFG_FOC_B 10'h262
// Function slot indices
`define DCSS_F_FUP 0
`define DCSS_F_FDN 1
`define DCSS_F_PUP 2
`define DCSS_F_PDN 3
`define DCSS_F_FF1 4
`define DCSS_F_FF2 5
`define DCSS_F_FF3 6
`define DCSS_F_FP1 7
`define DCSS_F_FP2 8
`define DCSS_F_JOG 9
`define DCSS_F_ACK 10
`define DCSS_F_THM 11
`define DCSS_F_NT 12
`define DCSS_F_DS1 13
`define DCSS_F_DS2 14
`define DCSS_NFUNC 15
`endif

// >>> rtl/dcss_pkg.sv
// Types for the drive control signal selector.
// Assumes dcss_defines.svh is in the include path.
package dcss_pkg;
  typedef logic [9:0] dcss_src_t;
  typedef enum logic [1:0] {
    DCSS_CTRL_SPEED,
    DCSS_CTRL_TORQUE
  } dcss_ctrl_e;
  typedef enum logic [1:0] {
    DCSS_MON_IDLE,
    DCSS_MON_SWITCH
  } dcss_mon_e;
endpackage : dcss_pkg

// >>> rtl/dcss_selector.sv
// Routes digital contacts and internal logic signals to drive functions.
// Assumes all inputs synchronous to i_core_clk; selections static-ish.
`timescale 1ns/1ns
`default_nettype none
`include "dcss_defines.svh"

// Notes on behaviour
// - Two set bits decode to sets one..four
// - Three bits index eight fixed frequencies
// - Two bits index four fixed percentages
// - Frequency potentiometer up/down pulses
// - Percentage potentiometer up/down pulses
// - Jog source level drives jog start
// - Acknowledge signal clears latched fault
// - Stop key resets only under keypad control
// - Input reset needs permission, a hardware input or an internal logic signal
// - Control word reset bit acknowledges fault
// - Thermocontact feeds motor temperature evaluation
// - Multifunction input digital in modes 3/4
// - Default thermocontact is multifunction input two
// - Changeover picks speed or torque controller
// - Changeover only in two configurations, monitored
// - Active set number is readable
// - Setup set zero writes all sets
// - Contacts evaluated only in contact modes; hardware variants in every mode
module dcss_selector (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [4:0] i_digital_inputs,
  input wire logic i_multifunction_input_one,
  input wire logic i_multifunction_input_two,
  input wire logic [2:0] i_mf1_mode,
  input wire logic [2:0] i_mf2_mode,
  input wire logic [15:0] i_logic_signals,
  input wire logic [2:0] i_ctrl_location,
  input wire logic [9:0] i_ctrl_config,
  input wire logic [`DCSS_NFUNC*10-1:0] i_source_sel,
  input wire logic i_fault_event,
  input wire logic i_stop_key,
  input wire logic i_ctrl_word_reset,
  input wire logic i_setup_write,
  input wire logic [2:0] i_setup_set,
  output logic o_freq_up,
  output logic o_freq_down,
  output logic o_pct_up,
  output logic o_pct_down,
  output logic [2:0] o_fixed_freq_index,
  output logic [1:0] o_fixed_pct_index,
  output logic o_jog_start,
  output logic o_fault_active,
  output logic o_thermo_contact,
  output logic o_torque_active,
  output logic o_changeover_busy,
  output logic [2:0] o_active_set,
  output logic [3:0] o_setup_set_we
);
  import dcss_pkg::*;

  // ----------------------------------------------------------------
  // Source mapping
  // ----------------------------------------------------------------
  wire logic contact_mode;
  wire logic keypad_mode;
  wire logic mf1_dig;
  wire logic mf2_dig;
  wire logic mf1_level;
  wire logic mf2_level;
  wire logic [`DCSS_NFUNC-1:0] func_level;
  wire logic [`DCSS_NFUNC-1:0] func_hw;

  assign contact_mode = (i_ctrl_location == `DCSS_LOC_CONTACT) ||
    (i_ctrl_location == `DCSS_LOC_CONTACT_K) ||
    (i_ctrl_location == `DCSS_LOC_3WIRE);
  assign keypad_mode = (i_ctrl_location == `DCSS_LOC_KEYPAD) ||
    (i_ctrl_location == `DCSS_LOC_KEYPAD_B) ||
    (i_ctrl_location == `DCSS_LOC_CONTACT_K);
  // Sinking mode: contact active at 0 V, so the pin is inverted
  assign mf1_dig = (i_mf1_mode == `DCSS_MF_SINKING) ||
    (i_mf1_mode == `DCSS_MF_SOURCING);
  assign mf2_dig = (i_mf2_mode == `DCSS_MF_SINKING) ||
    (i_mf2_mode == `DCSS_MF_SOURCING);
  assign mf1_level = mf1_dig & ((i_mf1_mode == `DCSS_MF_SINKING) ?
    ~i_multifunction_input_one : i_multifunction_input_one);
  assign mf2_level = mf2_dig & ((i_mf2_mode == `DCSS_MF_SINKING) ?
    ~i_multifunction_input_two : i_multifunction_input_two);

  genvar g;
  generate
    for (g = 0; g < `DCSS_NFUNC; g = g + 1) begin : g_func
      wire dcss_src_t sel;
      logic lvl;
      logic hw;
      logic [9:0] hwidx;
      logic [9:0] swidx;
      logic [9:0] invidx;
      assign sel = i_source_sel[g*10 +: 10];
      assign hwidx = sel - `DCSS_SRC_HW_IN1;
      assign swidx = sel - `DCSS_SRC_IN1;
      assign invidx = sel - `DCSS_SRC_INV_LO;
      always_comb begin
        lvl = 1'b0;
        hw = 1'b0;
        if (sel == `DCSS_SRC_ON) begin
          lvl = 1'b1;
        end else if (sel == `DCSS_SRC_OFF) begin
          lvl = 1'b0;
        end else if (sel >= `DCSS_SRC_IN1 && sel <= `DCSS_SRC_IN5) begin
          lvl = contact_mode & i_digital_inputs[swidx[2:0]];
        end else if (sel >= `DCSS_SRC_HW_IN1 &&
                     sel <= `DCSS_SRC_HW_IN5) begin
          lvl = i_digital_inputs[hwidx[2:0]];
          hw = 1'b1;
        end else if (sel == `DCSS_SRC_HW_MF1) begin
          lvl = mf1_level;
          hw = 1'b1;
        end else if (sel == `DCSS_SRC_HW_MF2) begin
          lvl = mf2_level;
          hw = 1'b1;
        end else if (sel >= `DCSS_SRC_INV_LO &&
                     sel <= `DCSS_SRC_INV_HI) begin
          // Inverted hardware variants, low active; the lowest code
          // mirrors a source that is no contact and so reads 0
          lvl = (invidx[2:0] != 3'h0 && invidx[2:0] < 3'h6) ?
            ~i_digital_inputs[invidx[2:0] - 3'h1] :
            (invidx[2:0] == 3'h6) ? ~mf1_level :
            (invidx[2:0] == 3'h7) ? ~mf2_level : 1'b0;
          hw = 1'b1;
        end else if (sel < 10'h010) begin
          // Internal logic signals are independent of control location
          lvl = i_logic_signals[sel[3:0]];
        end
      end
      assign func_level[g] = lvl;
      assign func_hw[g] = hw;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registered state
  // ----------------------------------------------------------------
  logic [`DCSS_NFUNC-1:0] level_q;
  logic fault_q;
  logic fault_d;
  dcss_ctrl_e ctrl_q;
  dcss_ctrl_e ctrl_d;
  dcss_mon_e mon_q;
  dcss_mon_e mon_d;
  logic [2:0] set_q;
  logic [2:0] set_d;
  logic [3:0] we_q;
  logic [3:0] we_d;
  logic stop_q;
  logic stop_rise;
  logic ack_rise;
  logic ack_ok;
  logic clear_fault;
  logic nt_allowed;
  wire logic ds1;
  wire logic ds2;

  assign ack_rise = func_level[`DCSS_F_ACK] & ~level_q[`DCSS_F_ACK];
  assign stop_rise = i_stop_key & ~stop_q;
  assign ack_ok = contact_mode | func_hw[`DCSS_F_ACK] |
    (i_source_sel[`DCSS_F_ACK*10 +: 10] < 10'h010);
  assign clear_fault = (ack_rise & ack_ok) |
    (stop_rise & keypad_mode) |
    i_ctrl_word_reset;
  // A new fault beats a simultaneous acknowledge
  assign fault_d = i_fault_event | (fault_q & ~clear_fault);

  assign nt_allowed = (i_ctrl_config == `DCSS_CFG_FOC_A) ||
    (i_ctrl_config == `DCSS_CFG_FOC_B);

  always_comb begin
    ctrl_d = ctrl_q;
    mon_d = DCSS_MON_IDLE;
    case (mon_q)
      DCSS_MON_IDLE: begin
        if (!nt_allowed) begin
          ctrl_d = DCSS_CTRL_SPEED;
        end else if (func_level[`DCSS_F_NT] !=
                     (ctrl_q == DCSS_CTRL_TORQUE)) begin
          mon_d = DCSS_MON_SWITCH;
        end
      end
      DCSS_MON_SWITCH: begin
        // One cycle of handover so both controllers see the transition
        ctrl_d = (nt_allowed && func_level[`DCSS_F_NT]) ? DCSS_CTRL_TORQUE :
          DCSS_CTRL_SPEED;
      end
      default: begin
        mon_d = DCSS_MON_IDLE;
      end
    endcase
  end

  assign ds1 = func_level[`DCSS_F_DS1];
  assign ds2 = func_level[`DCSS_F_DS2];
  // Gray order: 00->1, 10->2, 11->3, 01->4
  assign set_d = {1'b0, ds2, ds1 ^ ds2} + 3'h1;

  always_comb begin
    we_d = 4'h0;
    if (i_setup_write) begin
      if (i_setup_set == 3'h0) begin
        we_d = 4'hF;
      end else if (i_setup_set <= 3'h4) begin
        we_d = 4'h1 << (i_setup_set - 3'h1);
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      level_q <= '0;
      fault_q <= 1'b0;
      ctrl_q <= DCSS_CTRL_SPEED;
      mon_q <= DCSS_MON_IDLE;
      set_q <= 3'h1;
      we_q <= 4'h0;
      stop_q <= 1'b0;
    end else begin
      level_q <= func_level;
      fault_q <= fault_d;
      ctrl_q <= ctrl_d;
      mon_q <= mon_d;
      set_q <= set_d;
      we_q <= we_d;
      stop_q <= i_stop_key;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_freq_up = level_q[`DCSS_F_FUP] & ~level_q[`DCSS_F_FDN];
  assign o_freq_down = level_q[`DCSS_F_FDN] &
    ~level_q[`DCSS_F_FUP];
  assign o_pct_up = level_q[`DCSS_F_PUP] & ~level_q[`DCSS_F_PDN];
  assign o_pct_down = level_q[`DCSS_F_PDN] &
    ~level_q[`DCSS_F_PUP];
  assign o_fixed_freq_index = {level_q[`DCSS_F_FF3], level_q[`DCSS_F_FF2],
    level_q[`DCSS_F_FF1]};
  assign o_fixed_pct_index = {level_q[`DCSS_F_FP2],
    level_q[`DCSS_F_FP1]};
  assign o_jog_start = level_q[`DCSS_F_JOG];
  assign o_thermo_contact = level_q[`DCSS_F_THM];
  assign o_fault_active = fault_q;
  assign o_torque_active = (ctrl_q == DCSS_CTRL_TORQUE);
  assign o_changeover_busy = (mon_q == DCSS_MON_SWITCH);
  assign o_active_set = set_q;
  assign o_setup_set_we = we_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_set_decode;
    @(posedge i_core_clk) disable iff (i_rst)
    1'b1 |=> o_active_set == ($past(ds1) ? ($past(ds2) ? 3'h3 : 3'h2) :
      ($past(ds2) ? 3'h4 : 3'h1));
  endproperty
  a_set_decode: assert property (p_set_decode)
    else $error("active set decode wrong");

  property p_ff_index;
    @(posedge i_core_clk) disable iff (i_rst)
    1'b1 |=> o_fixed_freq_index == {$past(func_level[`DCSS_F_FF3]),
      $past(func_level[`DCSS_F_FF2]), $past(func_level[`DCSS_F_FF1])};
  endproperty
  a_ff_index: assert property (p_ff_index)
    else $error("fixed frequency index wrong");

  property p_fp_index;
    @(posedge i_core_clk) disable iff (i_rst)
    1'b1 |=> o_fixed_pct_index == {$past(func_level[`DCSS_F_FP2]),
      $past(func_level[`DCSS_F_FP1])};
  endproperty
  a_fp_index: assert property (p_fp_index)
    else $error("fixed percent index wrong");

  property p_pot_excl;
    @(posedge i_core_clk) disable iff (i_rst)
    !(o_freq_up && o_freq_down) && !(o_pct_up && o_pct_down);
  endproperty
  a_pot_excl: assert property (p_pot_excl)
    else $error("potentiometer up and down together");

  property p_fault_clear;
    @(posedge i_core_clk) disable iff (i_rst)
    (fault_q && i_ctrl_word_reset && !i_fault_event) |=> !o_fault_active;
  endproperty
  a_fault_clear: assert property (p_fault_clear)
    else $error("control word reset ignored");

  property p_key_gate;
    @(posedge i_core_clk) disable iff (i_rst)
    (fault_q && !keypad_mode && !i_fault_event && !i_ctrl_word_reset &&
     !(ack_rise && ack_ok)) |=> o_fault_active;
  endproperty
  a_key_gate: assert property (p_key_gate)
    else $error("fault cleared without permission");

  property p_nt_gate;
    @(posedge i_core_clk) disable iff (i_rst)
    (!nt_allowed ##1 !nt_allowed) |-> !o_torque_active;
  endproperty
  a_nt_gate: assert property (p_nt_gate)
    else $error("torque active outside allowed configuration");

  property p_setup_all;
    @(posedge i_core_clk) disable iff (i_rst)
    (i_setup_write && i_setup_set == 3'h0) |=> o_setup_set_we == 4'hF;
  endproperty
  a_setup_all: assert property (p_setup_all)
    else $error("set zero did not write all sets");

  property p_const_off;
    @(posedge i_core_clk) disable iff (i_rst)
    (i_source_sel[`DCSS_F_JOG*10 +: 10] == `DCSS_SRC_OFF) |=> !o_jog_start;
  endproperty
  a_const_off: assert property (p_const_off)
    else $error("constant off source seen active");

  property p_jog_level;
    @(posedge i_core_clk) disable iff (i_rst)
    1'b1 |=> o_jog_start == $past(func_level[`DCSS_F_JOG]);
  endproperty
  a_jog_level: assert property (p_jog_level)
    else $error("jog start does not follow its source");

  property p_thermo_feed;
    @(posedge i_core_clk) disable iff (i_rst)
    1'b1 |=> o_thermo_contact == $past(func_level[`DCSS_F_THM]);
  endproperty
  a_thermo_feed: assert property (p_thermo_feed)
    else $error("thermocontact does not follow its source");

  property p_fault_set;
    @(posedge i_core_clk) disable iff (i_rst)
    i_fault_event |=> o_fault_active;
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("fault event not latched");

  property p_ack_clear;
    @(posedge i_core_clk) disable iff (i_rst)
    (fault_q && ack_rise && ack_ok && !i_fault_event) |=> !o_fault_active;
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("permitted acknowledge did not clear fault");

  property p_busy_once;
    @(posedge i_core_clk) disable iff (i_rst)
    o_changeover_busy |=> !o_changeover_busy;
  endproperty
  a_busy_once: assert property (p_busy_once)
    else $error("changeover busy longer than one cycle");
endmodule : dcss_selector
`default_nettype wire

// >>> verif/dcss_far_model.sv
// Far-side model: contacts, multifunction pins, logic signals, fieldbus.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module dcss_far_model (
  output logic [4:0] o_contacts,
  output logic o_mf1_pin,
  output logic o_mf2_pin,
  output logic [15:0] o_logic,
  output logic o_word_reset
);
  initial begin
    o_contacts = '0;
    o_mf1_pin = 1'b0;
    o_mf2_pin = 1'b0;
    o_logic = '0;
    o_word_reset = 1'b0;
  end
  // Closed contact and 24 V pin both read as high
  task automatic drive(input logic [4:0] c, input logic m1,
                       input logic m2, input logic [15:0] l);
    o_contacts = c;
    o_mf1_pin = m1;
    o_mf2_pin = m2;
    o_logic = l;
  endtask : drive
  task automatic word_reset(input logic v);
    o_word_reset = v;
  endtask : word_reset
endmodule : dcss_far_model
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench of the signal selector with a far-side model.
// Assumes a 100 MHz clock and results one cycle after each input, torque changeover two cycles.
`timescale 1ns/1ns
`default_nettype none
`include "dcss_defines.svh"
module testbench;
  import dcss_pkg::*;
  typedef struct {int due; int id; logic [7:0] exp;} dcss_note_s;
  logic i_core_clk, i_rst, fev, stk, swr;
  logic [2:0] m1m, m2m, loc, sset;
  logic [9:0] cfg;
  logic [149:0] sel;
  wire logic [4:0] cts;
  wire logic mf1, mf2, wrst;
  wire logic [15:0] lsig;
  logic fu, fd, pu, pd, jog, flt, thm, trq, bsy;
  logic [2:0] ffi, aset;
  logic [1:0] fpi;
  logic [3:0] we;
  wire logic [20:0] obs;
  dcss_note_s notes[$];
  int failures, n_compared, cyc;
  logic [31:0] rnd;
  string nm [13] = '{"freq_up", "freq_down", "pct_up", "pct_down",
    "ff_index", "fp_index", "jog", "fault", "thermo", "torque", "busy",
    "active_set", "set_we"};
  int off [13] = '{0, 1, 2, 3, 4, 7, 9, 10, 11, 12, 13, 14, 17};
  int wd [13] = '{1, 1, 1, 1, 3, 2, 1, 1, 1, 1, 1, 3, 4};
  assign obs = {we, aset, bsy, trq, thm, flt, jog, fpi, ffi, pd, pu, fd, fu};

  dcss_far_model u_far (.o_contacts(cts), .o_mf1_pin(mf1),
    .o_mf2_pin(mf2), .o_logic(lsig), .o_word_reset(wrst));
  dcss_selector u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_digital_inputs(cts), .i_multifunction_input_one(mf1),
    .i_multifunction_input_two(mf2), .i_mf1_mode(m1m), .i_mf2_mode(m2m),
    .i_logic_signals(lsig), .i_ctrl_location(loc), .i_ctrl_config(cfg),
    .i_source_sel(sel), .i_fault_event(fev), .i_stop_key(stk),
    .i_ctrl_word_reset(wrst), .i_setup_write(swr), .i_setup_set(sset),
    .o_freq_up(fu), .o_freq_down(fd), .o_pct_up(pu), .o_pct_down(pd),
    .o_fixed_freq_index(ffi), .o_fixed_pct_index(fpi), .o_jog_start(jog),
    .o_fault_active(flt), .o_thermo_contact(thm), .o_torque_active(trq),
    .o_changeover_busy(bsy), .o_active_set(aset), .o_setup_set_we(we));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [7:0] seen(int id);
    return 8'((obs >> off[id]) & ((21'h1 << wd[id]) - 21'h1));
  endfunction : seen
  task automatic step(int k);
    repeat (k) @(posedge i_core_clk);
    #1;
  endtask : step
  // Latency counts edges from now; notes must be pushed in due order
  task automatic note(int id, logic [7:0] exp, int lat);
    notes.push_back('{cyc + lat, id, exp});
  endtask : note
  task automatic compare(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : compare
  task automatic fault_on();
    fev = 1'b1;
    step(1);
    fev = 1'b0;
    note(7, 8'h01, 0);
  endtask : fault_on
  task automatic close_out();
    if (failures == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Clock, monitor and watchdog
  // ----------------------------------------------------------------
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  initial begin
    dcss_note_s n;
    forever begin
      @(posedge i_core_clk);
      cyc++;
      #2;
      while (notes.size() > 0 && notes[0].due <= cyc) begin
        n = notes.pop_front();
        compare(nm[n.id], n.exp, seen(n.id));
      end
    end
  end
  initial begin
    #20000;
    failures++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    i_rst = 1'b1;
    {fev, stk, swr, sset, loc} = '0;
    cfg = `DCSS_CFG_FOC_A;
    m1m = `DCSS_MF_SINKING;
    m2m = `DCSS_MF_SINKING;
    sel = {15{`DCSS_SRC_OFF}};
    rnd = 32'ha03c;
    step(3);
    i_rst = 1'b0;
    note(11, 8'h01, 0);
    note(7, 8'h00, 0);
    sel[130+:10] = `DCSS_SRC_IN3;
    sel[140+:10] = `DCSS_SRC_IN4;
    for (int i = 0; i < 4; i++) begin
      u_far.drive({1'b0, i >= 2, i == 1 || i == 2, 2'b00}, 0, 0, 0);
      note(11, 8'(i + 1), 1);
      step(1);
    end
    loc = `DCSS_LOC_KEYPAD;
    u_far.drive(5'h0c, 0, 0, 0);
    note(11, 8'h01, 1);
    step(1);
    // Hardware variant of contact three still reads; contact four does not
    sel[130+:10] = 10'h210;
    note(11, 8'h02, 1);
    step(1);
    for (int k = 0; k < 9; k++) sel[k*10+:10] = 10'(k < 4 ? k + 8 : k - 4);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      u_far.drive(0, 0, 0, {4'h0, rnd[3:0], 3'b000, i[1:0], i[2:0]});
      note(0, 8'(rnd[0] & ~rnd[1]), 1);
      note(1, 8'(rnd[1] & ~rnd[0]), 1);
      note(2, 8'(rnd[2] & ~rnd[3]), 1);
      note(3, 8'(rnd[3] & ~rnd[2]), 1);
      note(4, 8'(i), 1);
      note(5, 8'(i[1:0]), 1);
      step(1);
    end
    sel[90+:10] = `DCSS_SRC_ON;
    note(6, 8'h01, 1);
    step(1);
    sel[90+:10] = `DCSS_SRC_OFF;
    note(6, 8'h00, 1);
    step(1);
    sel[110+:10] = `DCSS_SRC_HW_MF2;
    for (int i = 0; i < 5; i++) begin
      m2m = i < 2 ? `DCSS_MF_SINKING : (i < 4 ? `DCSS_MF_SOURCING : 3'h0);
      u_far.drive(0, 0, i == 1 || i == 2 || i == 4, 0);
      note(8, 8'(i == 0 || i == 2), 1);
      step(1);
    end
    sel[110+:10] = `DCSS_SRC_HW_MF1;
    m1m = `DCSS_MF_SOURCING;
    u_far.drive(0, 1, 0, 0);
    note(8, 8'h01, 1);
    step(1);
    // Inverted hardware variant of contact two, read outside contact modes
    sel[110+:10] = 10'h21b;
    u_far.drive(5'h02, 0, 0, 0);
    note(8, 8'h00, 1);
    step(1);
    u_far.drive(5'h00, 0, 0, 0);
    note(8, 8'h01, 1);
    step(1);
    sel[100+:10] = 10'h00c;
    loc = `DCSS_LOC_CONTACT;
    u_far.drive(0, 0, 0, 0);
    fault_on();
    u_far.drive(0, 0, 0, 16'h1000);
    note(7, 8'h00, 1);
    step(2);
    fault_on();
    stk = 1'b1;
    note(7, 8'h01, 1);
    step(1);
    stk = 1'b0;
    loc = `DCSS_LOC_KEYPAD;
    step(1);
    stk = 1'b1;
    note(7, 8'h00, 1);
    step(1);
    stk = 1'b0;
    sel[100+:10] = `DCSS_SRC_IN5;
    fault_on();
    u_far.drive(5'h10, 0, 0, 0);
    note(7, 8'h01, 1);
    step(1);
    u_far.drive(0, 0, 0, 0);
    sel[100+:10] = `DCSS_SRC_HW_IN5;
    step(1);
    u_far.drive(5'h10, 0, 0, 0);
    note(7, 8'h00, 1);
    step(1);
    fault_on();
    u_far.word_reset(1'b1);
    note(7, 8'h00, 1);
    step(1);
    u_far.word_reset(1'b0);
    sel[120+:10] = 10'h00d;
    for (int i = 0; i < 3; i++) begin
      cfg = i == 0 ? `DCSS_CFG_FOC_A : (i == 1 ? `DCSS_CFG_FOC_B : 10'h000);
      step(2);
      u_far.drive(0, 0, 0, 16'h2000);
      note(10, 8'(i < 2), 1);
      note(9, 8'(i < 2), 2);
      note(10, 8'h00, 2);
      step(3);
      u_far.drive(0, 0, 0, 0);
      note(9, 8'h00, 2);
      step(3);
    end
    for (int k = 0; k < 6; k++) begin
      swr = 1'b1;
      sset = 3'(k);
      note(12, k == 0 ? 8'h0f : (k < 5 ? 8'h01 << (k - 1) : 8'h00),
        1);
      note(12, 8'h00, 2);
      step(1);
      swr = 1'b0;
      step(2);
    end
    close_out();
  end
endmodule : testbench
`default_nettype wire
